// [hdl/sfdl_local_port.sv]
// Purpose: Local-bus FIFO port serving the bridge DMA channels.
// Assumes: Bridge DMA logic and serial channels share clk_in.
// Notes: One beat per request; ready is a one-cycle pulse.
`timescale 1ns/1ps

module sfdl_local_port (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire sfdl_pkg::sfdl_lreq_t lreq_in,
  input wire logic last_burst_strobe_in,
  output logic lready_out,
  output logic [31:0] lrdata_out,
  input wire sfdl_pkg::sfdl_tgt_t [1:0] dma_target_in,
  output logic [1:0] demand_request_n_out,
  input wire sfdl_pkg::sfdl_cfg_t cfg_in,
  output logic cfg_ack_out,
  output logic [31:0] cfg_rdata_out,
  input wire logic [1:0] dma_done_in,
  input wire logic local_irq_in,
  input wire logic local_irq_enable_in,
  output logic host_interrupt_line_out,
  input wire logic ee_data_in,
  output logic ee_clk_out,
  output logic ee_sel_out,
  input wire logic [3:0] rx_valid_in,
  input wire logic [3:0][7:0] rx_data_in,
  output logic [3:0] rx_ready_out,
  output logic [3:0] tx_valid_out,
  output logic [3:0][7:0] tx_data_out,
  input wire logic [3:0] tx_ready_in
);

  // Whole state of the port
  typedef struct packed {
    logic ready;
    logic last_write;
    logic [31:0] rdata;
    logic [1:0] demand_request_n_n;
    logic [1:0] hold_off;
    logic [1:0][31:0] setup;
    logic cfg_ack;
    logic [31:0] cfg_rdata;
    logic irq;
  } sfdl_st_t;

  sfdl_st_t st_reg, st_next;

  // FIFO handshakes seen by the local bus
  logic [3:0] tx_push;       // Local write into a transmit FIFO
  logic [3:0] tx_space;      // Transmit FIFO not full
  logic [3:0] rx_pop;        // Local read from a receive FIFO
  logic [3:0] rx_avail;      // Receive FIFO holds data
  logic [3:0][7:0] rx_head;  // Byte at the head of each receive FIFO

  // Identity words from the loader
  logic [31:0] ident;
  logic [31:0] sub_ident;
  logic ident_loaded;

  // Decode of the current local access
  logic take;     // A new beat is offered
  logic hit;      // Address falls on a FIFO port
  logic [1:0] idx; // Which FIFO port
  logic demand;   // Requesting channel is in demand mode
  logic stall;    // Demand mode waits on the serial side
  logic [31:0] wmask_data; // Setup write with reserved bits cleared

  assign lready_out = st_reg.ready;
  assign lrdata_out = st_reg.rdata;
  assign demand_request_n_out = st_reg.demand_request_n_n;
  assign cfg_ack_out = st_reg.cfg_ack;
  assign cfg_rdata_out = st_reg.cfg_rdata;
  assign host_interrupt_line_out = st_reg.irq;

  // Identity loader runs after every reset
  sfdl_ee_loader u_loader (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .ee_data_in(ee_data_in),
    .ee_clk_out(ee_clk_out),
    .ee_sel_out(ee_sel_out),
    .identity_out(ident),
    .sub_identity_out(sub_ident),
    .loaded_out(ident_loaded)
  );

  // One transmit and one receive FIFO per serial channel
  genvar g;
  generate
    for (g = 0; g < sfdl_pkg::NUM_FIFO; g++) begin : g_chan
      sfdl_fifo #(
        .W(sfdl_pkg::DATA_W),
        .DEPTH(sfdl_pkg::FIFO_DEPTH)
      ) u_tx (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .in_valid_in(tx_push[g]),
        .in_ready_out(tx_space[g]),
        .in_data_in(lreq_in.data[7:0]),
        .out_valid_out(tx_valid_out[g]),
        .out_ready_in(tx_ready_in[g]),
        .out_data_out(tx_data_out[g])
      );
      sfdl_fifo #(
        .W(sfdl_pkg::DATA_W),
        .DEPTH(sfdl_pkg::FIFO_DEPTH)
      ) u_rx (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .in_valid_in(rx_valid_in[g]),
        .in_ready_out(rx_ready_out[g]),
        .in_data_in(rx_data_in[g]),
        .out_valid_out(rx_avail[g]),
        .out_ready_in(rx_pop[g]),
        .out_data_out(rx_head[g])
      );
    end
  endgenerate

  // Address decode of the local access
  always_comb begin
    // A beat is taken only while no answer is pending
    take = lreq_in.valid && !st_reg.ready;
    // Only the four FIFO ports are DMA targets; 4k local space
    hit = (lreq_in.addr[sfdl_pkg::ADDR_W-1:sfdl_pkg::FIFO_WIN_LSB] ==
      sfdl_pkg::FIFO_BASE[sfdl_pkg::ADDR_W-1:sfdl_pkg::FIFO_WIN_LSB]);
    idx = lreq_in.addr[sfdl_pkg::FIFO_IDX_LSB +: 2];
    // Either channel may run in either mode
    demand = st_reg.setup[lreq_in.chan][sfdl_pkg::SU_DEMAND];
    // Demand mode waits for data or space; the other mode never looks
    stall = hit && demand &&
      (lreq_in.write ? !tx_space[idx] : !rx_avail[idx]);
    wmask_data = cfg_in.data & sfdl_pkg::SETUP_WMASK;
  end

  // FIFO strobes, one-hot on the addressed port
  always_comb begin
    tx_push = '0;
    rx_pop = '0;
    if (take && hit && !stall) begin
      // A full FIFO drops the write: initiator must size transfers
      if (lreq_in.write) begin
        tx_push[idx] = 1'b1;
      end else begin
        rx_pop[idx] = 1'b1;
      end
    end
  end

  // Next state of bus answers, demand requests, registers, interrupt
  always_comb begin
    st_next = st_reg;
    st_next.ready = 1'b0;
    st_next.cfg_ack = 1'b0;

    // Local bus beat: ready paces each access, waits only while demand mode stalls
    if (take && !stall) begin
      st_next.ready = 1'b1;
      st_next.last_write = lreq_in.write;
      if (!lreq_in.write && hit) begin
        // Byte in the low lane, upper lanes zero
        st_next.rdata = {24'h00_0000, rx_head[idx]};
      end else begin
        // Non-FIFO addresses answer zero and change nothing
        st_next.rdata = 32'h0000_0000;
      end
    end

    // Demand request per DMA channel, active low
    for (int k = 0; k < 2; k++) begin
      // Last beat of a burst pauses the request for one cycle
      st_next.hold_off[k] = take && !stall && (lreq_in.chan == k[0]) &&
        last_burst_strobe_in;
      if (st_reg.setup[k][sfdl_pkg::SU_DEMAND] && !st_reg.hold_off[k]) begin
        if (dma_target_in[k].to_fifo) begin
          // Transmit: ask while there is room
          st_next.demand_request_n_n[k] = !tx_space[dma_target_in[k].idx];
        end else begin
          // Receive: ask as soon as data arrives
          st_next.demand_request_n_n[k] = !rx_avail[dma_target_in[k].idx];
        end
      end else begin
        st_next.demand_request_n_n[k] = 1'b1;
      end
    end

    // Configuration port access, answered one cycle later
    if (cfg_in.valid) begin
      st_next.cfg_ack = 1'b1;
      st_next.cfg_rdata = 32'h0000_0000;
      case (cfg_in.addr)
        sfdl_pkg::OFF_IDENTITY: begin
          // Writes are ignored; reads zero until loaded
          st_next.cfg_rdata = ident_loaded ? ident : 32'h0;
        end
        sfdl_pkg::OFF_SUB_IDENTITY: begin
          st_next.cfg_rdata = ident_loaded ? sub_ident : 32'h0;
        end
        sfdl_pkg::OFF_WIN0: begin
          st_next.cfg_rdata = sfdl_pkg::WIN0_TYPE;
        end
        sfdl_pkg::OFF_WIN1: begin
          st_next.cfg_rdata = sfdl_pkg::WIN1_TYPE;
        end
        sfdl_pkg::OFF_WIN2: begin
          st_next.cfg_rdata = sfdl_pkg::WIN2_TYPE;
        end
        sfdl_pkg::OFF_WIN3: begin
          st_next.cfg_rdata = sfdl_pkg::WIN3_TYPE;
        end
        sfdl_pkg::OFF_SETUP0: begin
          if (cfg_in.write) begin
            st_next.setup[0] = wmask_data;
          end
          st_next.cfg_rdata = st_reg.setup[0];
        end
        sfdl_pkg::OFF_SETUP1: begin
          if (cfg_in.write) begin
            st_next.setup[1] = wmask_data;
          end
          st_next.cfg_rdata = st_reg.setup[1];
        end
        default: begin
          // Mailbox, doorbell and all else read zero
          st_next.cfg_rdata = 32'h0000_0000;
        end
      endcase
    end

    // One host line; each source needs its own enable as well
    st_next.irq =
      (dma_done_in[0] && st_reg.setup[0][sfdl_pkg::SU_DONE_IE]) ||
      (dma_done_in[1] && st_reg.setup[1][sfdl_pkg::SU_DONE_IE]) ||
      (local_irq_in && local_irq_enable_in);
  end

  // State register; setup starts in the supported transfer shape
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      st_reg <= '0;
      st_reg.demand_request_n_n <= 2'h3;
      st_reg.setup[0] <= sfdl_pkg::SETUP_RST;
      st_reg.setup[1] <= sfdl_pkg::SETUP_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // Ready is a single-cycle pulse, so beats cannot double count
  chk_ready_pulse: assert property (@(posedge clk_in) disable iff (reset_in)
    st_reg.ready |=> !st_reg.ready)
    else $error("Ready held for two cycles");

  // Every offered beat is answered unless demand mode stalls it
  chk_beat_answer: assert property (@(posedge clk_in) disable iff (reset_in)
    (take && !stall) |=> st_reg.ready)
    else $error("Beat not answered on next cycle");

  // A stalled demand beat gets no ready
  chk_demand_stall: assert property (@(posedge clk_in) disable iff (reset_in)
    (take && stall) |=> !st_reg.ready)
    else $error("Ready given while demand stalled");

  // Read answers carry one byte in the low lane
  chk_rdata_byte: assert property (@(posedge clk_in) disable iff (reset_in)
    (st_reg.ready && !st_reg.last_write) |-> st_reg.rdata[31:8] == 24'h0)
    else $error("Upper read lanes not zero");

  // Non-FIFO addresses never move FIFO data
  chk_unmapped_idle: assert property (@(posedge clk_in) disable iff (reset_in)
    (lreq_in.valid && !hit) |-> (tx_push == 4'h0 && rx_pop == 4'h0))
    else $error("FIFO moved on a non-FIFO address");

  // Channel 0 demand request only with demand mode set beforehand
  chk_demand_request_n_mode: assert property (@(posedge clk_in) disable iff (reset_in)
    !st_reg.demand_request_n_n[0] |-> $past(st_reg.setup[0][sfdl_pkg::SU_DEMAND]))
    else $error("Demand request without demand mode");

  // Reserved setup 1 bits stay zero whatever is written
  chk_setup_resvd: assert property (@(posedge clk_in) disable iff (reset_in)
    cfg_in.valid && cfg_in.write && cfg_in.addr == sfdl_pkg::OFF_SETUP1
    ##1 1'b1 |-> st_reg.setup[1][31:18] == 14'h0)
    else $error("Reserved setup bits set");

  // Identity stays fixed once loaded
  chk_id_fixed: assert property (@(posedge clk_in) disable iff (reset_in)
    (ident_loaded && $past(ident_loaded)) |-> $stable(ident))
    else $error("Identity changed after load");

  // An enabled local interrupt reaches the host on the next cycle
  chk_irq_merge: assert property (@(posedge clk_in) disable iff (reset_in)
    (local_irq_in && local_irq_enable_in) |=> st_reg.irq [*1])
    else $error("Enabled local interrupt not passed");

endmodule

// [hdl/sfdl_pkg.sv]
// Purpose: Constants and carriers of the FIFO DMA local port.
// Assumes: One 25 MHz clock, synchronous active-high reset.
// Notes: Offsets are byte addresses of the configuration port.
//
// What this block does
// - DMA targets only the four FIFO locations
// - Demand: request rx on data, tx while space
// - Demand transfer stalls when serial side stalls
// - Non-demand ignores FIFO empty and full flags
// - Both DMA channels serve demand and non-demand
// - FIFO accesses are 32-bit; width code 11/00
// - Bursts enabled, back-to-back FIFO accesses accepted
// - Demand mode drives active-low demand request
// - Identity codes loaded from EEPROM, read-only
// - Bridge setup loaded from SETUP_RST at reset
// - Windows: 0 memory, 1 IO, 2 memory, 3 unused
// - Local space size is 4k bytes
// - Mailbox and doorbell registers do nothing
// - DMA and local interrupts merge onto one line
// - Interrupt needs enable at every level

package sfdl_pkg;

  // Data path sizes
  localparam int NUM_FIFO = 4;
  localparam int DATA_W = 8;
  localparam int BUS_W = 32;
  localparam int FIFO_DEPTH = 8;

  // Local space of 4k bytes sets the local address width
  localparam int LOCAL_SPACE_BYTES = 4096;
  localparam int ADDR_W = $clog2(LOCAL_SPACE_BYTES);

  // FIFO data ports: one word each from FIFO_BASE upward
  localparam logic [11:0] FIFO_BASE = 12'h010;
  localparam int FIFO_IDX_LSB = 2;
  localparam int FIFO_WIN_LSB = 4;

  // Configuration port offsets
  localparam int CFG_AW = 8;
  localparam logic [7:0] OFF_IDENTITY = 8'h00;
  localparam logic [7:0] OFF_SUB_IDENTITY = 8'h2C;
  localparam logic [7:0] OFF_WIN0 = 8'h10;
  localparam logic [7:0] OFF_WIN1 = 8'h14;
  localparam logic [7:0] OFF_WIN2 = 8'h18;
  localparam logic [7:0] OFF_WIN3 = 8'h1C;
  localparam logic [7:0] OFF_SETUP0 = 8'h80;
  localparam logic [7:0] OFF_SETUP1 = 8'h94;

  // Window type words: bit 0 set marks IO space
  localparam logic [31:0] WIN0_TYPE = 32'h0000_0000;
  localparam logic [31:0] WIN1_TYPE = 32'h0000_0001;
  localparam logic [31:0] WIN2_TYPE = 32'h0000_0000;
  localparam logic [31:0] WIN3_TYPE = 32'h0000_0000;

  // Channel setup field positions
  localparam int SU_WIDTH_LSB = 0;
  localparam int SU_READY = 6;
  localparam int SU_BURST = 8;
  localparam int SU_DONE_IE = 10;
  localparam int SU_NOINC = 11;
  localparam int SU_DEMAND = 12;
  localparam int SU_STOP = 15;
  localparam logic [1:0] WIDTH_32 = 2'h3;
  localparam logic [1:0] WIDTH_8 = 2'h0;

  // Setup reset: 32-bit, ready on, burst on, no increment
  localparam logic [31:0] SETUP_RST = 32'h0000_0943;
  // Bits 31:18 are reserved and stay zero
  localparam logic [31:0] SETUP_WMASK = 32'h0003_FFFF;

  // EEPROM serial clock timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int EE_CLK_PERIOD_NS = 320;
  localparam int EE_HALF_CYC = EE_CLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam int EE_BITS = 64;

  // Local bus access from the bridge DMA controller
  typedef struct packed {
    logic valid;
    logic write;
    logic chan;
    logic [ADDR_W-1:0] addr;
    logic [BUS_W-1:0] data;
  } sfdl_lreq_t;

  // Which FIFO a DMA channel is working on
  typedef struct packed {
    logic to_fifo;
    logic [1:0] idx;
  } sfdl_tgt_t;

  // Configuration port access
  typedef struct packed {
    logic valid;
    logic write;
    logic [CFG_AW-1:0] addr;
    logic [BUS_W-1:0] data;
  } sfdl_cfg_t;

endpackage

// [hdl/sfdl_fifo.sv]
// Purpose: Small flip-flop FIFO with valid/ready on both sides.
// Assumes: Same clock on both sides.
// Notes: Push when full and pop when empty are ignored.
`timescale 1ns/1ps

module sfdl_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [W-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [W-1:0] out_data_out
);

  localparam int PW = $clog2(DEPTH);

  // Whole state of the FIFO
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0] wptr;
    logic [PW-1:0] rptr;
    logic [PW:0] count;
  } sfdl_fifo_st_t;

  sfdl_fifo_st_t st_reg, st_next;
  logic push, pop; // Handshakes that really move data

  assign in_ready_out = (st_reg.count != (PW+1)'(DEPTH));
  assign out_valid_out = (st_reg.count != '0);
  assign out_data_out = st_reg.mem[st_reg.rptr];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_ready_in && out_valid_out;

  // Pointer and count update
  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.mem[st_reg.wptr] = in_data_in;
      st_next.wptr = st_reg.wptr + 1'b1;
    end
    if (pop) begin
      st_next.rptr = st_reg.rptr + 1'b1;
    end
    // Simultaneous push and pop leaves the count
    st_next.count = st_reg.count + (PW+1)'(push) - (PW+1)'(pop);
  end

  // State register
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  chk_count_bound: assert property (@(posedge clk_in) disable iff (reset_in)
    st_reg.count <= (PW+1)'(DEPTH))
    else $error("FIFO count beyond depth");

endmodule

// [hdl/sfdl_ee_loader.sv]
// Purpose: Reads the identity words from the serial EEPROM at reset.
// Assumes: EEPROM shifts its next bit after our clock falls.
// Notes: Words are read-only once loaded; a reset reloads them.
`timescale 1ns/1ps

module sfdl_ee_loader (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic ee_data_in,
  output logic ee_clk_out,
  output logic ee_sel_out,
  output logic [31:0] identity_out,
  output logic [31:0] sub_identity_out,
  output logic loaded_out
);

  // Whole state of the loader
  typedef struct packed {
    logic [1:0] sync;
    logic [2:0] div;
    logic [6:0] bits;
    logic sck;
    logic sel;
    logic done;
    logic [63:0] shreg;
  } sfdl_ee_st_t;

  // Half period of the serial clock in system cycles
  localparam int EE_HALF_CYC = sfdl_pkg::EE_HALF_CYC;

  sfdl_ee_st_t st_reg, st_next;

  assign ee_clk_out = st_reg.sck;
  assign ee_sel_out = st_reg.sel;
  assign identity_out = st_reg.shreg[63:32];
  assign sub_identity_out = st_reg.shreg[31:0];
  assign loaded_out = st_reg.done;

  // Serial clock divider and shift; data passes two flops first
  always_comb begin
    st_next = st_reg;
    st_next.sync = {st_reg.sync[0], ee_data_in};
    if (!st_reg.done) begin
      st_next.sel = 1'b1;
      if (st_reg.div == 3'(EE_HALF_CYC - 1)) begin
        st_next.div = '0;
        st_next.sck = !st_reg.sck;
        // Sample on the rising edge; bit settled since the fall
        if (!st_reg.sck) begin
          st_next.shreg = {st_reg.shreg[62:0], st_reg.sync[1]};
          st_next.bits = st_reg.bits + 7'h01;
          if (st_reg.bits == 7'(sfdl_pkg::EE_BITS - 1)) begin
            st_next.done = 1'b1;
            st_next.sel = 1'b0;
          end
        end
      end else begin
        st_next.div = st_reg.div + 3'h1;
      end
    end else begin
      st_next.sck = 1'b0;
    end
  end

  // State register; reset restarts the load
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  chk_load_time: assert property (@(posedge clk_in) disable iff (reset_in)
    $fell(reset_in) |-> ##[500:560] st_reg.done)
    else $error("EEPROM load did not finish in time");

endmodule

// [tb/sfdl_dma_model.sv]
// Purpose: Bridge DMA controller model driving the local bus.
// Assumes: Tasks are entered between clock edges.
// Notes: Read data is queued in rd_q for the bench.
// Local side of a 32-bit 66MHz host bridge
// Chaining off: one burst per call, no descriptor fetch
// Caller picks burst length against FIFO depth
`timescale 1ns/1ps

module sfdl_dma_model (
  input wire logic clk_in,
  input wire logic lready_in,
  input wire logic [31:0] lrdata_in,
  output sfdl_pkg::sfdl_lreq_t lreq_out,
  output logic last_out
);
  logic [31:0] rd_q[$]; // Read beats in arrival order

  // Idle bus from time zero
  initial begin
    lreq_out = '0;
    last_out = 1'h0;
  end

  // Burst of n beats at one fixed FIFO port; gives up when a beat waits lim cycles
  task automatic run(input logic wr, input logic ch, input logic [11:0] a,
      input int n, input logic [7:0] d0, input int lim, output int done);
    int w;
    done = 0;
    @(posedge clk_in);
    for (int i = 0; i < n; i++) begin
      #1;
      lreq_out = '{1'h1, wr, ch, a, {24'h0, d0 + 8'(i)}};
      last_out = (i == n - 1);
      w = 0;
      // Hold everything until ready is sampled high
      do begin
        @(posedge clk_in);
        w++;
      end while (lready_in !== 1'h1 && w < lim);
      if (lready_in !== 1'h1) break;
      if (!wr) rd_q.push_back(lrdata_in);
      done++;
    end
    #1;
    // A released bus shows the inverse, never the stale value
    lreq_out.valid = 1'h0;
    lreq_out.data = ~lreq_out.data;
    last_out = 1'h0;
  endtask
endmodule

// [tb/testbench.sv]
// Purpose: Self-checking bench of the FIFO DMA local port.
// Assumes: Inputs change 1 ns after the rising edge.
// Notes: EEPROM data held high, so identity words load as all ones.
`timescale 1ns/1ps

module testbench;
  logic clk_in = 1'h0;
  logic reset_in = 1'h1;
  sfdl_pkg::sfdl_lreq_t lreq;
  sfdl_pkg::sfdl_cfg_t cfg = '0;
  sfdl_pkg::sfdl_tgt_t [1:0] tgt = '0;
  logic last, lready, cfg_ack, irq, ee_clk, ee_sel;
  logic ee_data = 1'h1;
  logic local_irq = 1'h0;
  logic local_en = 1'h0;
  logic [1:0] demand_request_n_n;
  logic [1:0] done_in = 2'h0;
  logic [31:0] lrdata, cfg_rdata, q;
  logic [3:0] rx_v = 4'h0;
  logic [3:0] tx_r = 4'h0;
  logic [3:0] rx_r, tx_v;
  logic [3:0][7:0] rx_d = '0;
  logic [3:0][7:0] tx_d;
  int err_total = 0;
  int num_checks = 0;
  int cyc = 0;
  int n;

  // 25 MHz clock
  always #20 clk_in = ~clk_in;

  sfdl_local_port DUT (
    .clk_in(clk_in), .reset_in(reset_in), .lreq_in(lreq),
    .last_burst_strobe_in(last), .lready_out(lready), .lrdata_out(lrdata),
    .dma_target_in(tgt), .demand_request_n_out(demand_request_n_n), .cfg_in(cfg),
    .cfg_ack_out(cfg_ack), .cfg_rdata_out(cfg_rdata), .dma_done_in(done_in),
    .local_irq_in(local_irq), .local_irq_enable_in(local_en),
    .host_interrupt_line_out(irq), .ee_data_in(ee_data),
    .ee_clk_out(ee_clk), .ee_sel_out(ee_sel), .rx_valid_in(rx_v),
    .rx_data_in(rx_d), .rx_ready_out(rx_r), .tx_valid_out(tx_v),
    .tx_data_out(tx_d), .tx_ready_in(tx_r)
  );

  sfdl_dma_model bridge (
    .clk_in(clk_in), .lready_in(lready), .lrdata_in(lrdata),
    .lreq_out(lreq), .last_out(last)
  );

  // Hang guard: the whole run needs well under 2000 cycles
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("checks=%0d mismatches=%0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge clk_in);
    #1;
  endtask

  // One config access; ack is due in the cycle after the take
  task automatic cfg_rw(input logic wr, input logic [7:0] a,
      input logic [31:0] d);
    tick(1);
    cfg = '{1'h1, wr, a, d};
    tick(1);
    cfg.valid = 1'h0;
    cfg.data = ~cfg.data;
    check(cfg_ack, 32'h1);
    q = cfg_rdata;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    cfg_rw(1'h0, a, 32'h0);
    check(q, exp);
  endtask

  task automatic t_regs();
    rd_chk(8'h80, 32'h0000_0943);
    rd_chk(8'h94, 32'h0000_0943);
    rd_chk(8'h10, 32'h0000_0000);
    rd_chk(8'h14, 32'h0000_0001);
    rd_chk(8'h18, 32'h0000_0000);
    rd_chk(8'h1C, 32'h0000_0000);
    rd_chk(8'h40, 32'h0000_0000);
    cfg_rw(1'h1, 8'h80, 32'hFFFF_FFFF);
    rd_chk(8'h80, 32'h0003_FFFF);
    cfg_rw(1'h1, 8'h00, 32'h0);
    rd_chk(8'h00, 32'hFFFF_FFFF);
    cfg_rw(1'h1, 8'h80, 32'h0000_0943);
    $display("regs test done");
  endtask

  // Overrun a stalled transmit FIFO, then drain it
  task automatic t_tx();
    bridge.run(1'h1, 1'h1, 12'h018, 10, 8'hA0, 4, n);
    check(n, 10);
    check(tx_v[2], 1'h1);
    tx_r[2] = 1'h1;
    for (int i = 0; i < 8; i++) begin
      check(tx_d[2], 8'hA0 + 8'(i));
      tick(1);
    end
    tx_r[2] = 1'h0;
    check(tx_v[2], 1'h0);
    $display("tx test done");
  endtask

  // Fill a receive FIFO until refused, read it past empty
  task automatic t_rx();
    rx_v[3] = 1'h1;
    for (int i = 0; i < 8; i++) begin
      rx_d[3] = 8'h50 + 8'(i);
      check(rx_r[3], 1'h1);
      tick(1);
    end
    rx_v[3] = 1'h0;
    rx_d[3] = ~rx_d[3];
    check(rx_r[3], 1'h0);
    bridge.run(1'h0, 1'h0, 12'h01C, 9, 8'h00, 4, n);
    check(n, 9);
    for (int i = 0; i < 8; i++)
      check(bridge.rd_q[i], 32'h50 + 32'(i));
    bridge.rd_q.delete();
    $display("rx test done");
  endtask

  // Demand requests and stalls on both channels
  task automatic t_demand();
    tgt[0] = '{1'h0, 2'h0};
    tgt[1] = '{1'h1, 2'h1};
    cfg_rw(1'h1, 8'h80, 32'h0000_1943);
    cfg_rw(1'h1, 8'h94, 32'h0000_1943);
    tick(2);
    check(demand_request_n_n, 2'h1);
    rx_v[0] = 1'h1;
    rx_d[0] = 8'h3C;
    tick(1);
    rx_v[0] = 1'h0;
    rx_d[0] = 8'hC3;
    tick(2);
    check(demand_request_n_n[0], 1'h0);
    bridge.run(1'h0, 1'h0, 12'h010, 2, 8'h00, 6, n);
    check(n, 1);
    check(bridge.rd_q[0], 32'h3C);
    bridge.rd_q.delete();
    bridge.run(1'h1, 1'h1, 12'h014, 9, 8'h70, 6, n);
    check(n, 8);
    tick(2);
    check(demand_request_n_n[1], 1'h1);
    tx_r[1] = 1'h1;
    tick(8);
    tx_r[1] = 1'h0;
    check(tx_v[1], 1'h0);
    cfg_rw(1'h1, 8'h80, 32'h0000_0943);
    cfg_rw(1'h1, 8'h94, 32'h0000_0943);
    tick(2);
    check(demand_request_n_n, 2'h3);
    $display("demand test done");
  endtask

  task automatic t_irq();
    cfg_rw(1'h1, 8'h94, 32'h0000_0D43);
    done_in = 2'h2;
    tick(2);
    check(irq, 1'h1);
    done_in = 2'h1;
    tick(2);
    check(irq, 1'h0);
    done_in = 2'h0;
    local_irq = 1'h1;
    tick(2);
    check(irq, 1'h0);
    local_en = 1'h1;
    tick(2);
    check(irq, 1'h1);
    local_irq = 1'h0;
    tick(2);
    check(irq, 1'h0);
    $display("irq test done");
  endtask

  // Reset for 8 cycles, wait out the identity load, run the tests
  initial begin
    tick(8);
    reset_in = 1'h0;
    tick(2);
    check(ee_sel, 1'h1);
    check(ee_clk, 1'h0);
    // Serial clock rises after four cycles of its divider
    tick(2);
    check(ee_clk, 1'h1);
    tick(598);
    check(ee_sel, 1'h0);
    check(ee_clk, 1'h0);
    rd_chk(8'h00, 32'hFFFF_FFFF);
    rd_chk(8'h2C, 32'hFFFF_FFFF);
    t_regs();
    t_tx();
    t_rx();
    t_demand();
    t_irq();
    complete_run();
  end
endmodule
